/* File: test/btsc_exec_asserts.sv */
`timescale 1ns/1ns
module btsc_exec_asserts (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        INSTR_VALID,
  input wire logic [2:0]  INSTR_OP,
  input wire logic [2:0]  INSTR_BIT_SEL,
  input wire logic [7:0]  REG_RDATA,
  input wire logic [10:0] PC_IN,
  input wire logic [7:0]  ACCUMULATOR_IN,
  input wire logic [7:0]  TABLE_HIGH_POINTER,
  input wire logic        BUSY,
  input wire logic        DISCARD_NEXT,
  input wire logic        ACCUMULATOR_WE,
  input wire logic [7:0]  ACCUMULATOR_WDATA,
  input wire logic        ZERO_WE,
  input wire logic        ZERO_WDATA,
  input wire logic        PC_LOAD,
  input wire logic [10:0] PC_LOAD_VAL,
  input wire logic        STACK_PUSH,
  input wire logic [10:0] STACK_WDATA
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  wire tk = INSTR_VALID && !BUSY;
  wire bv = REG_RDATA[INSTR_BIT_SEL];
  sequence call_s; tk && INSTR_OP == 3'h3; endsequence
  sequence clr_s; tk && INSTR_OP == 3'h4; endsequence
  sequence held_s; INSTR_VALID && BUSY; endsequence
  clear_value_a: assert property (clr_s |=>
    ACCUMULATOR_WE && ZERO_WE && ZERO_WDATA &&
    ACCUMULATOR_WDATA == 8'h00) else $error("bad clear");
  clear_fast_a: assert property (clr_s |=> !BUSY) else $error("slow");
  skip_clr_a: assert property (tk && INSTR_OP == 3'h1 && !bv |=>
    DISCARD_NEXT && BUSY) else $error("no skip");
  skip_set_a: assert property (tk && INSTR_OP == 3'h2 && bv |=>
    DISCARD_NEXT && BUSY) else $error("no skip");
  no_skip_a: assert property (tk && bv == (INSTR_OP == 3'h1) &&
    INSTR_OP inside {3'h1, 3'h2} |=> !DISCARD_NEXT && !BUSY) else
    $error("bad skip");
  busy_once_a: assert property (BUSY |=> !BUSY) else $error("busy");
  held_ignored_a: assert property (held_s |=>
    !ACCUMULATOR_WE && !PC_LOAD && !DISCARD_NEXT && !BUSY)
    else $error("busy request taken");
  call_tgt_a: assert property (call_s |=>
    PC_LOAD && PC_LOAD_VAL ==
    {$past(TABLE_HIGH_POINTER[2:0]), $past(ACCUMULATOR_IN)})
    else $error("target");
  call_push_a: assert property (call_s |=> STACK_PUSH && BUSY &&
    STACK_WDATA == $past(PC_IN) + 11'h001) else $error("push");
endmodule
bind btsc_exec btsc_exec_asserts btsc_exec_asserts_inst (
  .CLK                (CLK),
  .RST                (RST),
  .INSTR_VALID        (INSTR_VALID),
  .INSTR_OP           (INSTR_OP),
  .INSTR_BIT_SEL      (INSTR_BIT_SEL),
  .REG_RDATA          (REG_RDATA),
  .PC_IN              (PC_IN),
  .ACCUMULATOR_IN     (ACCUMULATOR_IN),
  .TABLE_HIGH_POINTER (TABLE_HIGH_POINTER),
  .BUSY               (BUSY),
  .DISCARD_NEXT       (DISCARD_NEXT),
  .ACCUMULATOR_WE     (ACCUMULATOR_WE),
  .ACCUMULATOR_WDATA  (ACCUMULATOR_WDATA),
  .ZERO_WE            (ZERO_WE),
  .ZERO_WDATA         (ZERO_WDATA),
  .PC_LOAD            (PC_LOAD),
  .PC_LOAD_VAL        (PC_LOAD_VAL),
  .STACK_PUSH         (STACK_PUSH),
  .STACK_WDATA        (STACK_WDATA)
);

/* File: test/test_btsc_exec.sv */
`timescale 1ns/1ns
module test_btsc_exec;
  logic CLK = 0, RST = 1, INSTR_VALID = 0, BUSY, DISCARD_NEXT;
  logic ACCUMULATOR_WE, ZERO_WE, ZERO_WDATA, PC_LOAD, STACK_PUSH, SP_WE, s;
  logic [2:0] INSTR_OP = 3'h0, INSTR_BIT_SEL = 3'h0, SP_IN = 3'h1;
  logic [2:0] STACK_WADDR, SP_WDATA;
  logic [6:0] INSTR_REG_ADDR = 7'h7F, REG_ADDR;
  logic [7:0] REG_RDATA = 8'h00, ACCUMULATOR_IN = 8'h34, ACCUMULATOR_WDATA;
  logic [7:0] TABLE_HIGH_POINTER = 8'hFA;
  logic [10:0] PC_IN = 11'h0A0, PC_LOAD_VAL, STACK_WDATA;
  int fails = 0, samples_checked = 0, cyc = 0;
  btsc_exec btsc_exec_inst (
    .CLK                (CLK),
    .RST                (RST),
    .INSTR_VALID        (INSTR_VALID),
    .INSTR_OP           (INSTR_OP),
    .INSTR_REG_ADDR     (INSTR_REG_ADDR),
    .INSTR_BIT_SEL      (INSTR_BIT_SEL),
    .REG_RDATA          (REG_RDATA),
    .PC_IN              (PC_IN),
    .ACCUMULATOR_IN     (ACCUMULATOR_IN),
    .TABLE_HIGH_POINTER (TABLE_HIGH_POINTER),
    .SP_IN              (SP_IN),
    .BUSY               (BUSY),
    .DISCARD_NEXT       (DISCARD_NEXT),
    .REG_ADDR           (REG_ADDR),
    .ACCUMULATOR_WE     (ACCUMULATOR_WE),
    .ACCUMULATOR_WDATA  (ACCUMULATOR_WDATA),
    .ZERO_WE            (ZERO_WE),
    .ZERO_WDATA         (ZERO_WDATA),
    .PC_LOAD            (PC_LOAD),
    .PC_LOAD_VAL        (PC_LOAD_VAL),
    .STACK_PUSH         (STACK_PUSH),
    .STACK_WDATA        (STACK_WDATA),
    .STACK_WADDR        (STACK_WADDR),
    .SP_WE              (SP_WE),
    .SP_WDATA           (SP_WDATA)
  );
  always #5 CLK = ~CLK;
  task complete_run;
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic ok, input string what);
    samples_checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask
  task run(input logic [2:0] op, input logic [7:0] rd);
    @(posedge CLK);
    #1;
    INSTR_OP = op;
    REG_RDATA = rd;
    INSTR_VALID = 1'b1;
    @(posedge CLK);
    #1;
    INSTR_VALID = 1'b0;
  endtask
  task t_skip;
    for (int o = 1; o < 3; o++)
      for (int b = 0; b < 8; b++)
        for (int v = 0; v < 2; v++) begin
          INSTR_BIT_SEL = 3'(b);
          INSTR_REG_ADDR = {3'(b), 4'hF};
          s = (o == 1) == (v == 0);
          run(3'(o), v ? 8'h01 << b : ~(8'h01 << b));
          chk(DISCARD_NEXT === s && BUSY === s, "skip");
          chk(REG_ADDR === {3'(b), 4'hF}, "address");
        end
  endtask
  task t_order;
    @(posedge CLK);
    #1;
    INSTR_OP = 3'h2;
    INSTR_BIT_SEL = 3'h5;
    REG_RDATA = 8'hDF;
    INSTR_VALID = 1'b1;
    @(posedge CLK);
    #1;
    INSTR_OP = 3'h4;
    chk(!BUSY && !DISCARD_NEXT, "no skip");
    @(posedge CLK);
    #1;
    INSTR_VALID = 1'b0;
    chk(ACCUMULATOR_WE === 1'b1 && ZERO_WE === 1'b1, "next");
  endtask
  task t_refuse;
    @(posedge CLK);
    #1;
    INSTR_OP = 3'h1;
    INSTR_BIT_SEL = 3'h0;
    REG_RDATA = 8'h00;
    INSTR_VALID = 1'b1;
    @(posedge CLK);
    #1;
    INSTR_OP = 3'h4;
    chk(BUSY === 1'b1 && DISCARD_NEXT === 1'b1, "skip");
    @(posedge CLK);
    #1;
    INSTR_VALID = 1'b0;
    chk(!ACCUMULATOR_WE && !BUSY && !DISCARD_NEXT, "held");
  endtask
  task t_call;
    run(3'h3, 8'h00);
    chk(PC_LOAD === 1'b1 && PC_LOAD_VAL === 11'h234, "target");
    chk(STACK_PUSH === 1'b1 && STACK_WDATA === 11'h0A1, "push");
    chk(STACK_WADDR === 3'h1 && SP_WDATA === 3'h2, "pointer");
    chk(SP_WE === 1'b1 && BUSY === 1'b1, "two cycles");
    @(posedge CLK);
    #1;
    chk(!STACK_PUSH && !SP_WE && !PC_LOAD && !BUSY, "one pulse");
    PC_IN = 11'h7FF;
    ACCUMULATOR_IN = 8'hC5;
    TABLE_HIGH_POINTER = 8'h05;
    SP_IN = 3'h7;
    run(3'h3, 8'h00);
    chk(PC_LOAD === 1'b1 && PC_LOAD_VAL === 11'h5C5, "target");
    chk(STACK_PUSH === 1'b1 && STACK_WDATA === 11'h000, "push");
    chk(STACK_WADDR === 3'h7 && SP_WDATA === 3'h0, "pointer");
  endtask
  task t_clr;
    run(3'h4, 8'h00);
    chk(ACCUMULATOR_WE === 1'b1 && BUSY === 1'b0, "write");
    chk(ACCUMULATOR_WDATA === 8'h00, "value");
    chk(ZERO_WE === 1'b1 && ZERO_WDATA === 1'b1, "zero");
    run(3'h0, 8'h00);
    chk(!ACCUMULATOR_WE && !ZERO_WE && !PC_LOAD && !BUSY, "idle op");
  endtask
  always @(posedge CLK) if (++cyc == 500) begin
    fails++;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge CLK);
    #1;
    RST = 1'b0;
    t_skip;
    t_order;
    t_refuse;
    t_call;
    t_clr;
    complete_run;
  end
endmodule

/* File: verilog/btsc_bitsel.v */
`timescale 1ns/1ns
`include "btsc_defines.vh"

// --------------------------------------------------------------
// Bit selector and skip decision
// --------------------------------------------------------------
module btsc_bitsel (
  input  wire [7:0] reg_data,
  input  wire [2:0] bit_sel,
  input  wire       want_set,
  output wire       skip
);
  wire picked;

  assign picked = reg_data[bit_sel];
  // Skip on a set bit for the set test, on a clear bit otherwise
  assign skip = want_set ? picked : ~picked;
endmodule

/* File: verilog/btsc_defines.vh */
`ifndef BTSC_DEFINES_VH
`define BTSC_DEFINES_VH

// --------------------------------------------------------------
// Operation codes presented by the fetch stage
// --------------------------------------------------------------
`define BTSC_OP_OTHER     3'h0
`define BTSC_OP_TSTCLR    3'h1
`define BTSC_OP_TSTSET    3'h2
`define BTSC_OP_CALLACC   3'h3
`define BTSC_OP_CLRACC    3'h4

// --------------------------------------------------------------
// Widths and fixed values
// --------------------------------------------------------------
`define BTSC_REG_ADDR_W   7
`define BTSC_BIT_SEL_W    3
`define BTSC_PC_W         11
`define BTSC_ACCUM_CLEAR  8'h00
`define BTSC_PTR_LSB      0
`define BTSC_PTR_MSB      2
`define BTSC_CALL_CYCLES  2'h2

`endif

/* File: verilog/btsc_exec.v */
`timescale 1ns/1ns
`include "btsc_defines.vh"

// --------------------------------------------------------------
// Execution of bit-test skips, indirect call and accumulator clear
// --------------------------------------------------------------
module btsc_exec #(
  parameter SP_W = 3
) (
  input  wire                      CLK,
  input  wire                      RST,
  input  wire                      INSTR_VALID,
  input  wire [2:0]                INSTR_OP,
  input  wire [6:0]                INSTR_REG_ADDR,
  input  wire [2:0]                INSTR_BIT_SEL,
  input  wire [7:0]                REG_RDATA,
  input  wire [10:0]               PC_IN,
  input  wire [7:0]                ACCUMULATOR_IN,
  input  wire [7:0]                TABLE_HIGH_POINTER,
  input  wire [SP_W-1:0]           SP_IN,
  output reg                       BUSY,
  output reg                       DISCARD_NEXT,
  output reg  [6:0]                REG_ADDR,
  output reg                       ACCUMULATOR_WE,
  output reg  [7:0]                ACCUMULATOR_WDATA,
  output reg                       ZERO_WE,
  output reg                       ZERO_WDATA,
  output reg                       PC_LOAD,
  output reg  [10:0]               PC_LOAD_VAL,
  output reg                       STACK_PUSH,
  output reg  [10:0]               STACK_WDATA,
  output reg  [SP_W-1:0]           STACK_WADDR,
  output reg                       SP_WE,
  output reg  [SP_W-1:0]           SP_WDATA
);

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_HOLD = 1'b1;

  localparam PC_W    = `BTSC_PC_W;

  reg             state_r;
  reg             state_nxt;
  wire            skip;
  wire            is_test;
  wire            is_set;
  wire            is_call;
  wire            is_clear;
  wire            go;
  wire            take_skip;
  wire            take_call;
  wire            take_clear;
  wire [PC_W-1:0] ret_addr;
  wire [PC_W-1:0] call_target;
  wire [SP_W-1:0] sp_next;

  assign go          = INSTR_VALID && (state_r == ST_IDLE);
  assign is_set      = (INSTR_OP == `BTSC_OP_TSTSET);
  assign is_test     = (INSTR_OP == `BTSC_OP_TSTCLR) || is_set;
  assign is_call     = (INSTR_OP == `BTSC_OP_CALLACC);
  assign is_clear    = (INSTR_OP == `BTSC_OP_CLRACC);
  assign take_skip   = go && is_test && skip;
  assign take_call   = go && is_call;
  assign take_clear  = go && is_clear;
  // Both wrap at their width; the core owns any overflow policy
  assign ret_addr    = PC_IN + {{(PC_W-1){1'b0}}, 1'b1};
  assign sp_next     = SP_IN + {{(SP_W-1){1'b0}}, 1'b1};
  assign call_target = {TABLE_HIGH_POINTER[`BTSC_PTR_MSB:`BTSC_PTR_LSB],
                        ACCUMULATOR_IN};

  btsc_bitsel btsc_bitsel_inst (
    .reg_data (REG_RDATA),
    .bit_sel  (INSTR_BIT_SEL),
    .want_set (is_set),
    .skip     (skip)
  );

  // ------------------------------------------------------------
  // Cycle sequencing
  // ------------------------------------------------------------
  // A skipped test and the call both occupy a second cycle;
  // the core must hold fetch while BUSY is high.
  always @* begin
    state_nxt = ST_IDLE;
    case (state_r)
      ST_IDLE: begin
        if (take_skip)
          state_nxt = ST_HOLD;
        else if (take_call)
          state_nxt = ST_HOLD;
      end
      ST_HOLD: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // State register and busy flag
  // ------------------------------------------------------------
  // BUSY mirrors the held state so that the core sees it from a flop
  always @(posedge CLK) begin
    if (RST) begin
      state_r <= ST_IDLE;
      BUSY    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      BUSY    <= (state_nxt == ST_HOLD);
    end
  end

  // ------------------------------------------------------------
  // Skip strobe and register address
  // ------------------------------------------------------------
  always @(posedge CLK) begin
    if (RST) begin
      DISCARD_NEXT <= 1'b0;
      REG_ADDR     <= 7'h00;
    end else begin
      DISCARD_NEXT <= take_skip;
      REG_ADDR     <= INSTR_REG_ADDR;
    end
  end

  // ------------------------------------------------------------
  // Accumulator and zero flag writes
  // ------------------------------------------------------------
  // Data outputs keep their last value between strobes
  always @(posedge CLK) begin
    if (RST) begin
      ACCUMULATOR_WE    <= 1'b0;
      ACCUMULATOR_WDATA <= 8'h00;
      ZERO_WE           <= 1'b0;
      ZERO_WDATA        <= 1'b0;
    end else begin
      ACCUMULATOR_WE <= take_clear;
      ZERO_WE        <= take_clear;
      if (take_clear) begin
        ACCUMULATOR_WDATA <= `BTSC_ACCUM_CLEAR;
        ZERO_WDATA        <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Return address push
  // ------------------------------------------------------------
  always @(posedge CLK) begin
    if (RST) begin
      STACK_PUSH  <= 1'b0;
      STACK_WDATA <= 11'h000;
      STACK_WADDR <= {SP_W{1'b0}};
    end else begin
      STACK_PUSH <= take_call;
      if (take_call) begin
        STACK_WDATA <= ret_addr;
        STACK_WADDR <= SP_IN;
      end
    end
  end

  // ------------------------------------------------------------
  // Stack pointer advance
  // ------------------------------------------------------------
  // No overflow check: a deep call chain silently overwrites entries
  always @(posedge CLK) begin
    if (RST) begin
      SP_WE    <= 1'b0;
      SP_WDATA <= {SP_W{1'b0}};
    end else begin
      SP_WE <= take_call;
      if (take_call)
        SP_WDATA <= sp_next;
    end
  end

  // ------------------------------------------------------------
  // Program counter load
  // ------------------------------------------------------------
  always @(posedge CLK) begin
    if (RST) begin
      PC_LOAD     <= 1'b0;
      PC_LOAD_VAL <= 11'h000;
    end else begin
      PC_LOAD <= take_call;
      if (take_call)
        PC_LOAD_VAL <= call_target;
    end
  end

endmodule
